// *** include/abrd_cfg.svh ***
// constants for the auto-baud rate detector
//
// Operation
// RULE_01: measure only in asynchronous mode and while wake-on-break enable is clear.
// RULE_02: a start bit seen while armed begins the measurement sequence.
// RULE_03: setting the arm bit clears the divider counter, then waits for start.
// RULE_04: the remote end sends a 55h sync character for measurement.
// RULE_05: in measurement the receive line times the divider counter.
// RULE_06: counting starts at the first rising edge after the start bit.
// RULE_07: fifth rising edge leaves the divisor in place and clears the arm bit.
// RULE_08: counter wrap from FFFFh to 0000h sets the overflow flag.
// RULE_09: overflow flag is set by hardware and writable by software.
// RULE_10: after a wrap, measurement continues and the arm bit stays set.
// RULE_11: counter clock during measurement is one eighth of the configured rate.
// RULE_12: counter clock is oscillator over 512, 128 or 32 by the select bits.
// RULE_13: both divisor bytes count as one 16-bit counter while measuring.
// RULE_14: the receive state machine is held idle while measuring.
// RULE_15: fifth rising edge sets receive-complete; a buffer read clears it.
// RULE_16: with wake-on-break set, measurement uses the character after the break; here wake-on-break set blocks the start bit instead.
// RULE_17: software must not write the transmit buffer while armed.
// RULE_18: software must not arm during a transmission.
// RULE_19: software keeps the incoming baud rate within the measurable range.
// RULE_20: asynchronous mode is selected by a clear synchronous-mode bit.
// RULE_21: with both selects set, bit rate is oscillator over four times divisor plus one.
`ifndef ABRD_CFG_SVH
`define ABRD_CFG_SVH

// ***************************************************
// prescale ratios
// ***************************************************
`define ABRD_MEAS_DIV_NONE 512
`define ABRD_MEAS_DIV_ONE 128
`define ABRD_MEAS_DIV_BOTH 32
`define ABRD_MEAS_RATIO 8

// ***************************************************
// sequence and reset values
// ***************************************************
`define ABRD_LAST_EDGE 3'h5
`define ABRD_DIVISOR_RST 16'h0000
`define ABRD_DIVISOR_MAX 16'hFFFF

`endif

// *** include/abrd_pkg.sv ***
// types for the auto-baud rate detector
package abrd_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_START,
        ST_WAIT_RISE,
        ST_COUNT
    } abrd_state_t;

    typedef struct packed {
        abrd_state_t state;
        logic arm;
        logic measuring;
        logic [15:0] divisor;
        logic overflow;
        logic rxComplete;
        logic [2:0] edges;
        logic [15:0] rateCnt;
        logic bitTick;
        logic preClear;
        logic rxMeta;
        logic rxSync;
        logic rxPrev;
    } abrd_regs_t;

endpackage

// *** verilog/abrd_prescaler.sv ***
// counter clock prescaler producing a one-cycle enable pulse
`timescale 1ns/1ps
`include "abrd_cfg.svh"
module abrd_prescaler #(
    parameter int PRE_W = 9
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // control
    input wire logic clear,
    input wire logic measure,
    input wire logic wideDividerSelect,
    input wire logic highSpeedSelect,
    // enable out
    output logic tick
);

    logic [PRE_W-1:0] cnt_q;
    logic [PRE_W-1:0] cnt_d;
    logic tick_d;

    // elaboration check: the counter must hold the slowest ratio
    if ((2 ** PRE_W) < `ABRD_MEAS_DIV_NONE) begin : g_pre_too_small
        $error("abrd_prescaler: PRE_W too small for the slowest ratio");
    end

    // reload value: period minus one for the selected ratio
    function automatic logic [PRE_W-1:0] reloadOf(input logic meas, input logic wide,
                                                   input logic high);
        int period;
        period = `ABRD_MEAS_DIV_NONE;
        if (wide && high) begin
            period = `ABRD_MEAS_DIV_BOTH;
        end else if (wide || high) begin
            period = `ABRD_MEAS_DIV_ONE;
        end
        if (!meas) begin
            period = period / `ABRD_MEAS_RATIO; // see RULE_11
        end
        return PRE_W'(period - 1);
    endfunction

    // count down, pulse at zero, restart on clear
    always_comb begin
        tick_d = 1'b0;
        cnt_d = cnt_q - PRE_W'(1);
        if (clear) begin
            cnt_d = reloadOf(measure, wideDividerSelect, highSpeedSelect);
        end else if (cnt_q == '0) begin
            tick_d = 1'b1; // see RULE_12
            cnt_d = reloadOf(measure, wideDividerSelect, highSpeedSelect);
        end
    end

    // registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end

endmodule // abrd_prescaler

// *** verilog/abrd_detector.sv ***
// auto-baud measurement and baud divider for the enhanced serial port
`timescale 1ns/1ps
`include "abrd_cfg.svh"
module abrd_detector #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // serial line
    input wire logic rxPin,
    // configuration
    input wire logic syncModeSelect,
    input wire logic wakeOnBreakEnable,
    input wire logic wideDividerSelect,
    input wire logic highSpeedSelect,
    // software strobes
    input wire logic autoBaudArmSet,
    input wire logic autoBaudArmClear,
    input wire logic divisorLowWrite,
    input wire logic divisorHighWrite,
    input wire logic [7:0] divisorWriteData,
    input wire logic overflowWrite,
    input wire logic overflowWriteData,
    input wire logic receiveBufferRead,
    // status
    output logic autoBaudArm,
    output logic autoBaudMeasurement,
    output logic autoBaudOverflowFlag,
    output logic receiveCompleteFlag,
    output logic [7:0] baudDivisorLow,
    output logic [7:0] baudDivisorHigh,
    output logic rxHoldIdle,
    output logic transmitLockout,
    output logic bitRateTick
);

    abrd_pkg::abrd_regs_t q;
    abrd_pkg::abrd_regs_t n;
    logic preTick;
    logic rxFall;
    logic rxRise;
    logic asyncMode;

    // elaboration check: both divisor bytes form exactly one 16-bit counter
    if (CNT_W != 16) begin : g_bad_cnt_width
        $error("abrd_detector: divider counter must be 16 bits");
    end

    // edge count after one more rising edge, wraps in three bits
    function automatic logic [2:0] edgeAfter(input logic [2:0] edges);
        return 3'(edges + 3'h1);
    endfunction

    // ***************************************************
    // counter clock prescaler
    // ***************************************************
    abrd_prescaler #(
        .PRE_W(9)
    ) u_abrd_prescaler (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clear(q.preClear),
        .measure(q.measuring),
        .wideDividerSelect(wideDividerSelect),
        .highSpeedSelect(highSpeedSelect),
        .tick(preTick)
    );

    // ***************************************************
    // line edges and mode
    // ***************************************************
    assign rxFall = q.rxPrev & ~q.rxSync;
    assign rxRise = ~q.rxPrev & q.rxSync;
    assign asyncMode = ~syncModeSelect; // see RULE_20

    // ***************************************************
    // next state
    // ***************************************************
    always_comb begin
        n = q;
        n.bitTick = 1'b0;
        n.preClear = 1'b0;
        // two-stage synchroniser then edge history
        n.rxMeta = rxPin;
        n.rxSync = q.rxMeta;
        n.rxPrev = q.rxSync;

        // software side effects
        if (divisorLowWrite && !q.measuring) begin
            n.divisor[7:0] = divisorWriteData;
        end
        if (divisorHighWrite && !q.measuring) begin
            n.divisor[15:8] = divisorWriteData;
        end
        if (overflowWrite) begin
            n.overflow = overflowWriteData; // see RULE_09
        end
        if (receiveBufferRead) begin
            n.rxComplete = 1'b0; // see RULE_15
        end
        if (autoBaudArmSet && !q.arm) begin
            n.arm = 1'b1;
            n.measuring = 1'b1; // see RULE_14
            n.divisor = `ABRD_DIVISOR_RST; // see RULE_03
            n.state = abrd_pkg::ST_WAIT_START;
        end

        case (q.state)
            abrd_pkg::ST_IDLE: begin
                // normal bit-rate generator from the divisor
                if (preTick) begin
                    if (q.rateCnt == 16'h0000) begin
                        n.bitTick = 1'b1; // see RULE_21
                        n.rateCnt = wideDividerSelect ? q.divisor : {8'h00, q.divisor[7:0]};
                    end else begin
                        n.rateCnt = 16'(q.rateCnt - 16'h0001);
                    end
                end
            end
            abrd_pkg::ST_WAIT_START: begin
                // start bit is ignored while wake-on-break enable is set
                if (asyncMode && !wakeOnBreakEnable && rxFall) begin // see RULE_01, RULE_16
                    n.state = abrd_pkg::ST_WAIT_RISE; // see RULE_02
                end
            end
            abrd_pkg::ST_WAIT_RISE: begin
                if (rxRise) begin
                    n.state = abrd_pkg::ST_COUNT; // see RULE_06
                    n.edges = 3'h1;
                    n.preClear = 1'b1;
                end
            end
            abrd_pkg::ST_COUNT: begin
                // line edges gate the divider as a bit timer
                if (preTick) begin
                    n.divisor = 16'(q.divisor + 16'h0001); // see RULE_05, RULE_13
                    if (q.divisor == `ABRD_DIVISOR_MAX) begin
                        n.overflow = 1'b1; // see RULE_08, RULE_10
                    end
                end
                // fifth rising edge ends the sync character
                if (rxRise) begin
                    if (edgeAfter(q.edges) == `ABRD_LAST_EDGE) begin
                        n.arm = 1'b0; // see RULE_07
                        n.measuring = 1'b0;
                        n.rxComplete = 1'b1; // see RULE_15
                        n.state = abrd_pkg::ST_IDLE;
                        n.rateCnt = 16'h0000;
                    end else begin
                        n.edges = edgeAfter(q.edges);
                    end
                end
            end
            default: begin
                n.state = abrd_pkg::ST_IDLE;
            end
        endcase

        // software abort of an armed sequence
        if (autoBaudArmClear) begin
            n.arm = 1'b0;
            n.measuring = 1'b0;
            n.state = abrd_pkg::ST_IDLE;
        end
    end

    // ***************************************************
    // state register
    // ***************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // line history resets to idle high so no false edge follows reset
            q <= '{
                state: abrd_pkg::ST_IDLE,
                arm: 1'b0,
                measuring: 1'b0,
                divisor: `ABRD_DIVISOR_RST,
                overflow: 1'b0,
                rxComplete: 1'b0,
                edges: 3'h0,
                rateCnt: 16'h0000,
                bitTick: 1'b0,
                preClear: 1'b0,
                rxMeta: 1'b1,
                rxSync: 1'b1,
                rxPrev: 1'b1
            };
        end else begin
            q <= n;
        end
    end

    // ***************************************************
    // outputs straight from flops
    // ***************************************************
    assign autoBaudArm = q.arm;
    assign autoBaudMeasurement = q.measuring;
    assign autoBaudOverflowFlag = q.overflow;
    assign receiveCompleteFlag = q.rxComplete;
    assign baudDivisorLow = q.divisor[7:0];
    assign baudDivisorHigh = q.divisor[15:8];
    assign rxHoldIdle = q.measuring; // see RULE_14
    assign transmitLockout = q.arm; // see RULE_17
    assign bitRateTick = q.bitTick;

endmodule // abrd_detector

// *** test/abrd_detector_assertions.sv ***
// port assertions for the auto-baud rate detector
`timescale 1ns/1ps
module abrd_detector_assertions (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // inputs
    input wire logic syncModeSelect,
    input wire logic wakeOnBreakEnable,
    input wire logic autoBaudArmClear,
    input wire logic overflowWrite,
    input wire logic overflowWriteData,
    input wire logic receiveBufferRead,
    // outputs
    input wire logic autoBaudArm,
    input wire logic autoBaudMeasurement,
    input wire logic autoBaudOverflowFlag,
    input wire logic receiveCompleteFlag,
    input wire logic [7:0] baudDivisorLow,
    input wire logic [7:0] baudDivisorHigh,
    input wire logic rxHoldIdle,
    input wire logic transmitLockout
);
    // ***********************************
    // divider pair seen as one counter
    // ***********************************
    logic [15:0] div;
    assign div = {baudDivisorHigh, baudDivisorLow};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_arm_clears_div: assert property ($rose(autoBaudArm) |-> div == 16'h0000)
        else $error("divisor not cleared on arm");
    chk_done_flags: assert property (
        $fell(autoBaudMeasurement) && !$past(autoBaudArmClear)
        |-> receiveCompleteFlag && !autoBaudArm)
        else $error("completion flags wrong");
    chk_div_step: assert property (
        autoBaudMeasurement && $past(autoBaudMeasurement)
        && !$stable(div) |-> div == $past(div) + 16'h0001)
        else $error("counter step wrong");
    chk_wrap_flag: assert property (
        $past(autoBaudMeasurement) && $past(div) == 16'hFFFF
        && div == 16'h0000 |-> autoBaudOverflowFlag && autoBaudArm)
        else $error("wrap not trapped");
    chk_sw_overflow: assert property (
        overflowWrite && !autoBaudMeasurement
        |=> autoBaudOverflowFlag == $past(overflowWriteData))
        else $error("overflow write lost");
    chk_read_clears: assert property (
        receiveBufferRead && !autoBaudMeasurement
        |=> !receiveCompleteFlag)
        else $error("read did not clear");
    chk_start_blocked: assert property (
        autoBaudMeasurement && div == 16'h0000
        && (syncModeSelect || wakeOnBreakEnable) |=> div == 16'h0000)
        else $error("counted while blocked");
    chk_hold_idle: assert property (rxHoldIdle == autoBaudMeasurement)
        else $error("receiver not held idle");
    chk_tx_lock: assert property (transmitLockout == autoBaudArm)
        else $error("transmit lockout wrong");
endmodule // abrd_detector_assertions
bind abrd_detector abrd_detector_assertions u_abrd_detector_assertions (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .syncModeSelect(syncModeSelect),
    .wakeOnBreakEnable(wakeOnBreakEnable),
    .autoBaudArmClear(autoBaudArmClear),
    .overflowWrite(overflowWrite),
    .overflowWriteData(overflowWriteData),
    .receiveBufferRead(receiveBufferRead),
    .autoBaudArm(autoBaudArm),
    .autoBaudMeasurement(autoBaudMeasurement),
    .autoBaudOverflowFlag(autoBaudOverflowFlag),
    .receiveCompleteFlag(receiveCompleteFlag),
    .baudDivisorLow(baudDivisorLow),
    .baudDivisorHigh(baudDivisorHigh),
    .rxHoldIdle(rxHoldIdle),
    .transmitLockout(transmitLockout)
);

// *** test/abrd_sync_sender.sv ***
// remote serial sender of one framed character
`timescale 1ns/1ps
module abrd_sync_sender (
    // clock
    input wire logic core_clk,
    // serial line
    output logic rxPin
);
    // line idles high between frames
    initial rxPin = 1'b1;
    // start bit, eight bits lsb first, stop bit
    task automatic send(input int bitCycles, input logic [7:0] value);
        logic [9:0] frame;
        frame = {1'b1, value, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxPin <= frame[i];
            repeat (bitCycles) @(posedge core_clk);
        end
    endtask
endmodule // abrd_sync_sender

// *** test/abrd_detector_tb_top.sv ***
// self-checking bench for the auto-baud rate detector
`timescale 1ns/1ps
module abrd_detector_tb_top;
    logic core_clk = 1'b0, rst_n = 1'b0, rxPin, syncModeSelect = 1'b0, wakeOnBreakEnable = 1'b0;
    logic wideDividerSelect = 1'b0, highSpeedSelect = 1'b0, autoBaudArmSet = 1'b0;
    logic autoBaudArmClear = 1'b0, divisorLowWrite = 1'b0, divisorHighWrite = 1'b0;
    logic [7:0] divisorWriteData = 8'h00, baudDivisorLow, baudDivisorHigh;
    logic overflowWrite = 1'b0, overflowWriteData = 1'b0, receiveBufferRead = 1'b0;
    logic autoBaudArm, autoBaudMeasurement, autoBaudOverflowFlag, receiveCompleteFlag;
    logic rxHoldIdle, transmitLockout, bitRateTick;
    int n_fail = 0, compares = 0, cycles = 0;
    // ***********************************
    // clock, design and far side
    // ***********************************
    always #2.5 core_clk = ~core_clk;
    abrd_detector u_abrd_detector (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .rxPin(rxPin),
        .syncModeSelect(syncModeSelect),
        .wakeOnBreakEnable(wakeOnBreakEnable),
        .wideDividerSelect(wideDividerSelect),
        .highSpeedSelect(highSpeedSelect),
        .autoBaudArmSet(autoBaudArmSet),
        .autoBaudArmClear(autoBaudArmClear),
        .divisorLowWrite(divisorLowWrite),
        .divisorHighWrite(divisorHighWrite),
        .divisorWriteData(divisorWriteData),
        .overflowWrite(overflowWrite),
        .overflowWriteData(overflowWriteData),
        .receiveBufferRead(receiveBufferRead),
        .autoBaudArm(autoBaudArm),
        .autoBaudMeasurement(autoBaudMeasurement),
        .autoBaudOverflowFlag(autoBaudOverflowFlag),
        .receiveCompleteFlag(receiveCompleteFlag),
        .baudDivisorLow(baudDivisorLow),
        .baudDivisorHigh(baudDivisorHigh),
        .rxHoldIdle(rxHoldIdle),
        .transmitLockout(transmitLockout),
        .bitRateTick(bitRateTick)
    );
    abrd_sync_sender u_abrd_sync_sender (.core_clk(core_clk), .rxPin(rxPin));
    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (n_fail == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask
    task automatic pulse(ref logic sig);
        sig = 1'b1;
        cyc(1);
        sig = 1'b0;
    endtask
    // full sync measurement, each bit period two counter ticks of p cycles
    task automatic meas(input logic w, input logic h, input int p);
        logic [15:0] got;
        wideDividerSelect = w;
        highSpeedSelect = h;
        pulse(autoBaudArmSet);
        divisorWriteData = 8'hAA;
        pulse(divisorLowWrite);
        check(autoBaudArm === 1'b1 && baudDivisorLow === 8'h00, "arm or clear");
        check(rxHoldIdle === 1'b1 && transmitLockout === 1'b1, "hold or lock");
        u_abrd_sync_sender.send(2 * p, 8'h55);
        cyc(4);
        got = {baudDivisorHigh, baudDivisorLow};
        check(autoBaudArm === 1'b0 && receiveCompleteFlag === 1'b1, "end flags");
        check(rxHoldIdle === 1'b0 && autoBaudMeasurement === 1'b0, "hold kept");
        check(transmitLockout === 1'b0, "lock kept");
        check(got >= 16'h000F && got <= 16'h0011, "divisor");
        pulse(receiveBufferRead);
        check(receiveCompleteFlag === 1'b0, "complete kept");
    endtask
    // start bits ignored in synchronous mode or with wake set
    task automatic blocked(input logic s, input logic wk);
        syncModeSelect = s;
        wakeOnBreakEnable = wk;
        pulse(autoBaudArmSet);
        u_abrd_sync_sender.send(64, 8'h55);
        cyc(4);
        check(autoBaudArm === 1'b1 && receiveCompleteFlag === 1'b0, "not blocked");
        syncModeSelect = 1'b0;
        wakeOnBreakEnable = 1'b0;
        pulse(autoBaudArmClear);
        check(autoBaudArm === 1'b0 && autoBaudMeasurement === 1'b0, "abort");
    endtask
    task automatic ovf_write();
        overflowWriteData = 1'b1;
        pulse(overflowWrite);
        check(autoBaudOverflowFlag === 1'b1, "overflow set");
        cyc(1);
        overflowWriteData = 1'b0;
        pulse(overflowWrite);
        check(autoBaudOverflowFlag === 1'b0, "overflow clear");
    endtask
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (bitRateTick !== 1'b1 && n < 200);
    endtask
    // normal rate with both selects: four cycles times divisor plus one
    task automatic rate_tick();
        int gap;
        wideDividerSelect = 1'b1;
        highSpeedSelect = 1'b1;
        divisorWriteData = 8'h03;
        pulse(divisorLowWrite);
        divisorWriteData = 8'h00;
        pulse(divisorHighWrite);
        wait_tick(gap);
        wait_tick(gap);
        wait_tick(gap);
        check(gap == (32 / 8) * (3 + 1), "bit rate period");
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        cyc(1);
        meas(1'b0, 1'b0, 512);
        meas(1'b0, 1'b1, 128);
        meas(1'b1, 1'b0, 128);
        meas(1'b1, 1'b1, 32);
        blocked(1'b1, 1'b0);
        blocked(1'b0, 1'b1);
        ovf_write();
        rate_tick();
        end_of_test();
    end
endmodule // abrd_detector_tb_top
